/* File: src/gfx_vme_pkg.sv */
// constants, field layout and carrier types of the board's slave front end
// assumes a single 50 MHz system clock for all users of the package
package gfx_vme_pkg;

    // address modifiers that the board answers
    localparam logic [5:0] AM_SUPER_DATA = 6'h3D;
    localparam logic [5:0] AM_USER_DATA = 6'h39;

    // address layout
    localparam int ADDR_AREA_BIT = 15;
    localparam int ADDR_SEL_HI = 23;
    localparam int ADDR_SEL_LO = 16;

    // register select codes on address bits 2..1
    localparam logic [1:0] SEL_IDENT = 2'h0;
    localparam logic [1:0] SEL_CTRL = 2'h1;
    localparam logic [1:0] SEL_PTR = 2'h2;
    localparam logic [1:0] SEL_WIN = 2'h3;

    // control word fields
    localparam int CTL_CLRIF = 15;
    localparam int CTL_IEN_LO = 8;
    localparam int CTL_RST = 6;
    localparam int CTL_VP_LO = 3;
    localparam int CTL_PP_LO = 0;
    localparam int PF_CONT = 0;
    localparam int PF_HLT = 1;
    localparam int PF_START_FROM_ZERO = 2;

    // interrupt enable field codes
    localparam logic [1:0] IEN_KEEP = 2'h0;
    localparam logic [1:0] IEN_ON = 2'h1;
    localparam logic [1:0] IEN_OFF = 2'h2;
    localparam logic [1:0] IEN_TOG = 2'h3;

    // identity word upper byte
    localparam logic [7:0] ID_HIGH_ONES = 8'hFF;

    // microstore column at which the pointer advances
    localparam logic [1:0] COL_LAST = 2'h3;

    // reset values
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [1:0] COL_RESET = 2'h0;

    // shared memory size
    localparam int SHM_WORDS = 16384;

    typedef struct packed {
        logic [23:1] addr;
        logic [5:0] am;
        logic as_n;
        logic [1:0] ds_n;
        logic lword_n;
        logic write_n;
        logic [15:0] data;
    } vme_req_s;

    localparam vme_req_s REQ_IDLE = '{addr: 23'h000000, am: 6'h00,
        as_n: 1'b1, ds_n: 2'h3, lword_n: 1'b1, write_n: 1'b1,
        data: 16'h0000};

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_ACK = 4'b0010,
        S_BERR = 4'b0100,
        S_SKIP = 4'b1000
    } bus_state_e;

endpackage : gfx_vme_pkg

/* File: src/vme_run_control.sv */
// slave front end: register page, shared memory, run control of two cores
// assumes asynchronous bus pins and straps, core-side signals on clk_in
//
// Contract
// - select 00 reads identity; a write there gets bus error
// - select 01 writes control, reads status
// - select 10 is microstore pointer, 11 the data window, both r/w
// - address bits 14..3 ignored on the register page
// - register page: bytes act as words, longwords get bus error
// - answer only modifiers 3D/39 inside the strapped 64K block
// - bit 15 high picks shared memory, low picks registers
// - word field is a 14-bit index into 16K x 16 memory
// - shared memory takes bytes and words, longwords get bus error
// - identity holds the 7-bit ID_PATTERN parameter in 7..1, ones above
// - identity bit 0 is the buffer jumper; 1 blocks the link
// - writing clear-interrupt one clears the pending flag
// - enable field: 00 keep, 01 on, 10 off, 11 toggle
// - reset bit held high keeps the board inert
// - reset halts both cores, disables interrupts, resets side logic
// - halt stops the selected core's clocks
// - continue starts core at zero if modifier set, else resumes
// - halt and continue act only on a written rising edge
// - start-from-zero sampled only when continue rises
// - halt and continue together toggle run state
// - core first runs its held instruction, then fetches
// - bus requests of that first cycle are blocked
// - pointer write returns the column to zero
// - every four window accesses advance the pointer
`timescale 1ns/1ps
`default_nettype none

module vme_run_control
    import gfx_vme_pkg::*;
#(
    parameter logic [6:0] ID_PATTERN = 7'h2A  // arbitrary value
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // bus pins
    input wire logic [23:1] vme_addr_in,
    input wire logic [5:0] vme_am_in,
    input wire logic vme_as_n_in,
    input wire logic [1:0] vme_ds_n_in,
    input wire logic vme_lword_n_in,
    input wire logic vme_write_n_in,
    input wire logic [15:0] vme_data_in,
    output logic [15:0] vme_data_out,
    output logic vme_data_oe_n_out,
    output logic vme_dtack_n_out,
    output logic vme_berr_n_out,
    // straps
    input wire logic [7:0] board_select_in,
    input wire logic frame_buffer_attached_n_in,
    // board side
    input wire logic irq_event_in,
    input wire logic [7:0] status_flags_in,
    output logic irq_out,
    output logic board_reset_out,
    output logic fb_link_enable_out,
    // cores: index 1 viewing_processor, index 0 painting_processor
    output logic [1:0] proc_run_out,
    output logic [1:0] proc_start_out,
    output logic [1:0] proc_from_zero_out,
    input wire logic [1:0] proc_bus_req_in,
    output logic [1:0] proc_bus_req_out,
    // microstore port
    output logic [14:0] ustore_addr_out,
    output logic [1:0] ustore_col_out,
    output logic ustore_wr_out,
    output logic [15:0] ustore_wdata_out,
    input wire logic [15:0] ustore_rdata_in
);

    vme_req_s pin_req;
    vme_req_s req_s1_r;
    vme_req_s req_s2_r;
    logic [8:0] strap_s1_r;
    logic [8:0] strap_s2_r;
    bus_state_e state_r;
    bus_state_e state_nxt;
    logic [15:0] ctl_r;
    logic [15:0] ptr_r;
    logic [15:0] ptr_nxt;
    logic [1:0] col_r;
    logic [1:0] col_nxt;
    logic ien_r;
    logic ien_nxt;
    logic iflg_r;
    logic iflg_nxt;
    logic [1:0] run_r;
    logic [1:0] run_nxt;
    logic [1:0] start_r;
    logic [1:0] start_nxt;
    logic [1:0] from_zero_r;
    logic [1:0] bus_req_r;
    logic [15:0] data_r;
    logic oe_n_r;
    logic dtack_n_r;
    logic berr_n_r;
    logic irq_r;
    logic board_reset_r;
    logic fb_link_r;
    logic [14:0] uaddr_r;
    logic [1:0] ucol_r;
    logic uwr_r;
    logic [15:0] uwdata_r;
    logic [15:0] shm_mem [SHM_WORDS];

    // pins pass two flops before use
    assign pin_req = '{addr: vme_addr_in, am: vme_am_in, as_n: vme_as_n_in,
        ds_n: vme_ds_n_in, lword_n: vme_lword_n_in,
        write_n: vme_write_n_in, data: vme_data_in};

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            req_s1_r <= REQ_IDLE;
            req_s2_r <= REQ_IDLE;
            strap_s1_r <= 9'h000;
            strap_s2_r <= 9'h000;
        end else begin
            req_s1_r <= pin_req;
            req_s2_r <= req_s1_r;
            strap_s1_r <= {board_select_in, frame_buffer_attached_n_in};
            strap_s2_r <= strap_s1_r;
        end
    end

    // decode
    wire [7:0] board_sel = strap_s2_r[8:1];
    wire fb_jumper = strap_s2_r[0];
    wire strobe = !req_s2_r.as_n && !(&req_s2_r.ds_n);
    wire released = &req_s2_r.ds_n;
    wire am_ok = (req_s2_r.am == AM_SUPER_DATA) ||
        (req_s2_r.am == AM_USER_DATA);
    wire blk_ok = req_s2_r.addr[ADDR_SEL_HI:ADDR_SEL_LO] == board_sel;
    wire is_shm = req_s2_r.addr[ADDR_AREA_BIT];
    wire is_wr = !req_s2_r.write_n;
    wire is_lword = !req_s2_r.lword_n;
    wire [1:0] sel = req_s2_r.addr[2:1];
    wire [13:0] shm_idx = req_s2_r.addr[14:1];
    wire start_acc = (state_r == S_IDLE) && strobe;
    wire hit = start_acc && am_ok && blk_ok;
    wire bad = is_lword ||
        (!is_shm && sel == SEL_IDENT && is_wr);
    wire go = hit && !bad;
    wire reg_wr = go && !is_shm && is_wr;
    wire ctl_wr = reg_wr && sel == SEL_CTRL;
    wire ptr_wr = reg_wr && sel == SEL_PTR;
    wire win_acc = go && !is_shm && sel == SEL_WIN;
    wire shm_wr = go && is_shm && is_wr;
    wire [15:0] wdata = req_s2_r.data;

    // control word effects
    wire rst_new = ctl_wr ? wdata[CTL_RST] : ctl_r[CTL_RST];
    wire [1:0] ien_cmd = wdata[CTL_IEN_LO +: 2];
    wire clr_irq = ctl_wr && wdata[CTL_CLRIF];

    // reset bit clears interrupt state while high
    always_comb begin
        ien_nxt = ien_r;
        if (ctl_wr) begin
            case (ien_cmd)
                IEN_ON: ien_nxt = 1'b1;
                IEN_OFF: ien_nxt = 1'b0;
                IEN_TOG: ien_nxt = !ien_r;
                default: ien_nxt = ien_r;
            endcase
        end
        if (rst_new) begin
            ien_nxt = 1'b0;
        end
    end

    // set wins over clear
    assign iflg_nxt = rst_new ? 1'b0 :
        ((irq_event_in && ien_r) || (iflg_r && !clr_irq));

    // per core run control
    logic [1:0] cont_rise;
    logic [1:0] hlt_rise;
    logic [1:0] start_from_zero_wr;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_core
            localparam int BASE = (gi == 1) ? CTL_VP_LO : CTL_PP_LO;
            wire [2:0] fnew = wdata[BASE +: 3];
            wire [2:0] fold = ctl_r[BASE +: 3];
            assign cont_rise[gi] = ctl_wr && fnew[PF_CONT] &&
                !fold[PF_CONT];
            assign hlt_rise[gi] = ctl_wr && fnew[PF_HLT] &&
                !fold[PF_HLT];
            assign start_from_zero_wr[gi] = fnew[PF_START_FROM_ZERO];
            assign run_nxt[gi] = rst_new ? 1'b0 :
                (cont_rise[gi] && hlt_rise[gi]) ? !run_r[gi] :
                cont_rise[gi] ? 1'b1 :
                hlt_rise[gi] ? 1'b0 :
                run_r[gi];
            assign start_nxt[gi] = run_nxt[gi] && !run_r[gi];
        end
    endgenerate

    // microstore pointer and column
    assign col_nxt = ptr_wr ? COL_RESET :
        win_acc ? col_r + 2'h1 : col_r;
    assign ptr_nxt = ptr_wr ? wdata :
        (win_acc && col_r == COL_LAST) ? ptr_r + 16'h0001 :
        ptr_r;

    // read data
    wire [15:0] ident_word = {ID_HIGH_ONES, ID_PATTERN, fb_jumper};
    wire [15:0] status_word = {iflg_r, ien_r, col_r, 1'b1, ctl_r[CTL_RST],
        run_r[1], run_r[0], status_flags_in};
    wire [15:0] reg_rd = (sel == SEL_IDENT) ? ident_word :
        (sel == SEL_CTRL) ? status_word :
        (sel == SEL_PTR) ? ptr_r : ustore_rdata_in;

    // bus handshake
    always_comb begin
        case (state_r)
            S_IDLE: state_nxt = !start_acc ? S_IDLE :
                !hit ? S_SKIP : bad ? S_BERR : S_ACK;
            S_ACK, S_BERR, S_SKIP: state_nxt = released ? S_IDLE : state_r;
            default: state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_r <= S_IDLE;
            dtack_n_r <= 1'b1;
            berr_n_r <= 1'b1;
            oe_n_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            dtack_n_r <= !(state_nxt == S_ACK);
            berr_n_r <= !(state_nxt == S_BERR);
            oe_n_r <= !(state_nxt == S_ACK && (go ? !is_wr : !oe_n_r));
        end
    end

    // shared memory, byte lanes follow the data strobes
    always_ff @(posedge clk_in) begin
        if (shm_wr && !req_s2_r.ds_n[1]) begin
            shm_mem[shm_idx][15:8] <= wdata[15:8];
        end
        if (shm_wr && !req_s2_r.ds_n[0]) begin
            shm_mem[shm_idx][7:0] <= wdata[7:0];
        end
        if (go && !is_wr) begin
            data_r <= is_shm ? shm_mem[shm_idx] : reg_rd;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ctl_r <= CTL_RESET;
            ptr_r <= PTR_RESET;
            col_r <= COL_RESET;
            ien_r <= 1'b0;
            iflg_r <= 1'b0;
            run_r <= 2'h0;
            start_r <= 2'h0;
            from_zero_r <= 2'h0;
        end else begin
            if (ctl_wr) begin
                ctl_r <= wdata;
            end
            ptr_r <= ptr_nxt;
            col_r <= col_nxt;
            ien_r <= ien_nxt;
            iflg_r <= iflg_nxt;
            run_r <= run_nxt;
            start_r <= start_nxt;
            for (int i = 0; i < 2; i++) begin
                if (start_nxt[i]) begin
                    from_zero_r[i] <= start_from_zero_wr[i];
                end
            end
        end
    end

    // outputs toward the board
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            irq_r <= 1'b0;
            board_reset_r <= 1'b1;
            fb_link_r <= 1'b0;
            bus_req_r <= 2'h0;
            uaddr_r <= 15'h0000;
            ucol_r <= 2'h0;
            uwr_r <= 1'b0;
            uwdata_r <= 16'h0000;
        end else begin
            irq_r <= iflg_r && ien_r;
            board_reset_r <= ctl_r[CTL_RST];
            fb_link_r <= !fb_jumper;
            bus_req_r <= proc_bus_req_in & ~start_r;
            uaddr_r <= ptr_r[14:0];
            ucol_r <= col_r;
            uwr_r <= win_acc && is_wr;
            uwdata_r <= wdata;
        end
    end

    assign vme_data_out = data_r;
    assign vme_data_oe_n_out = oe_n_r;
    assign vme_dtack_n_out = dtack_n_r;
    assign vme_berr_n_out = berr_n_r;
    assign irq_out = irq_r;
    assign board_reset_out = board_reset_r;
    assign fb_link_enable_out = fb_link_r;
    assign proc_run_out = run_r;
    assign proc_start_out = start_r;
    assign proc_from_zero_out = from_zero_r;
    assign proc_bus_req_out = bus_req_r;
    assign ustore_addr_out = uaddr_r;
    assign ustore_col_out = ucol_r;
    assign ustore_wr_out = uwr_r;
    assign ustore_wdata_out = uwdata_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    ident_write_berr_a: assert property (hit && !is_shm && is_wr &&
        sel == SEL_IDENT |=> !vme_berr_n_out && vme_dtack_n_out)
        else $error("identity write not refused");
    status_read_a: assert property (go && !is_wr && !is_shm &&
        sel == SEL_CTRL |=> vme_data_out == $past(status_word))
        else $error("status word wrong");
    ptr_load_a: assert property (ptr_wr |=>
        ptr_r == $past(wdata) && col_r == COL_RESET)
        else $error("pointer load wrong");
    lword_berr_a: assert property (hit && is_lword |=>
        !vme_berr_n_out ##1 vme_dtack_n_out)
        else $error("longword not refused");
    foreign_am_a: assert property (start_acc && !am_ok |=>
        (vme_dtack_n_out && vme_berr_n_out) [*2])
        else $error("foreign modifier answered");
    ident_word_a: assert property (go && !is_wr && !is_shm &&
        sel == SEL_IDENT |=> vme_data_out[15:8] == ID_HIGH_ONES &&
        vme_data_out[7:1] == ID_PATTERN)
        else $error("identity word wrong");
    ien_toggle_a: assert property (ctl_wr && ien_cmd == IEN_TOG &&
        !rst_new |=> ien_r != $past(ien_r))
        else $error("enable did not toggle");
    irq_set_a: assert property (irq_event_in && ien_r &&
        !rst_new |=> iflg_r ##1 irq_out)
        else $error("interrupt flag lost");
    rst_halts_a: assert property (ctl_r[CTL_RST] |->
        run_r == 2'h0 && !ien_r && !iflg_r)
        else $error("reset bit left board active");
    start_zero_a: assert property (cont_rise[0] && !hlt_rise[0] &&
        !run_r[0] && !rst_new |=> proc_run_out[0] && proc_start_out[0] &&
        proc_from_zero_out[0] == $past(start_from_zero_wr[0]))
        else $error("continue start wrong");
    no_edge_hold_a: assert property (ctl_wr && !cont_rise[1] &&
        !hlt_rise[1] && !rst_new |=> run_r[1] == $past(run_r[1]))
        else $error("run changed without edge");
    both_toggle_a: assert property (cont_rise[1] && hlt_rise[1] &&
        !rst_new |=> run_r[1] != $past(run_r[1]))
        else $error("run state not toggled");
    first_block_a: assert property (proc_start_out[0] |=>
        !proc_bus_req_out[0])
        else $error("first cycle bus request passed");
    col_wrap_a: assert property (win_acc && col_r == COL_LAST |=>
        col_r == COL_RESET && ptr_r == $past(ptr_r) + 16'h0001)
        else $error("pointer did not advance");

    shm_write_c: cover property (shm_wr ##[1:8] !vme_dtack_n_out);
    core_start_c: cover property (cont_rise[1] ##1 proc_start_out[1]);
    berr_c: cover property (!vme_berr_n_out);
    ptr_advance_c: cover property (win_acc && col_r == COL_LAST);

endmodule : vme_run_control

`default_nettype wire

/* File: dv/vme_host_model.sv */
// host bus master model: runs one slave bus cycle at a time
// assumes registered slave answers on the same clock as the model
`timescale 1ns/1ps
`default_nettype none

module vme_host_model
    import gfx_vme_pkg::*;
(
    // clock
    input wire logic clk_in,
    // slave answers
    input wire logic dtack_n_in,
    input wire logic berr_n_in,
    input wire logic [15:0] rdata_in,
    // master pins
    output var vme_req_s req_out
);
    initial req_out = REQ_IDLE;

    // resp: 0 no answer, 1 acknowledge, 2 bus error
    task automatic host_cycle(input logic [23:1] a, input logic [5:0] am,
        input logic [1:0] ds, input logic lw, input logic wn,
        input logic [15:0] wd, output logic [15:0] rd,
        output logic [1:0] resp);
        int n;
        @(posedge clk_in);
        req_out <= '{addr: a, am: am, as_n: 1'b0, ds_n: ds, lword_n: lw,
            write_n: wn, data: wn ? ~wd : wd};
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (dtack_n_in && berr_n_in && n < 10);
        resp = !dtack_n_in ? 2'h1 : (!berr_n_in ? 2'h2 : 2'h0);
        rd = rdata_in;
        // released address and modifier lines carry the inverse of their last value
        req_out <= '{addr: ~a, am: ~am, as_n: 1'b1, ds_n: 2'h3,
            lword_n: 1'b1, write_n: 1'b1, data: ~wd};
        // strobes stay high until the answer is withdrawn
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while ((!(dtack_n_in && berr_n_in) || n < 4) && n < 20);
    endtask : host_cycle
endmodule : vme_host_model

`default_nettype wire

/* File: dv/test_vme_slave_register_and_run_control.sv */
// self-checking bench of the slave front end and run control
// assumes the host model in dv/ and the package in src/
`timescale 1ns/1ps
`default_nettype none

module test_vme_slave_register_and_run_control;
    import gfx_vme_pkg::*;
    logic clk_in = 1'b0;
    logic resetn = 1'b0;
    vme_req_s req;
    logic [7:0] bsel = 8'h00, flags = 8'h00;
    logic fbn = 1'b0, irq_ev = 1'b0;
    logic [1:0] breq = 2'h0, run, start, fz, breq_out, ucol, rsp;
    logic [1:0] rq_prev, st_prev;
    logic [15:0] dout, uwd, rd, p, d, wd_seen;
    logic [16:0] wa_seen;
    logic [14:0] uaddr;
    logic oe_n, oe_last, dtack_n, berr_n, irq, brst, fbl, uwr, e;
    logic rq_ok = 1'b0;
    logic [13:0] idx [8];
    logic [15:0] mem [8];
    logic [19:0] run_tbl [10] = '{20'h00000, 20'h50005, 20'h50004,
        20'h10002, 20'h10000, 20'h40001, 20'h40000, 20'h00003, 20'h00000,
        20'hE003B};
    int err_count = 0, check_count = 0, cyc = 0, start_cnt = 0;

    always #10 clk_in = ~clk_in;

    vme_run_control i_vme_run_control (.clk_in(clk_in), .resetn_in(resetn),
        .vme_addr_in(req.addr), .vme_am_in(req.am), .vme_as_n_in(req.as_n),
        .vme_ds_n_in(req.ds_n), .vme_lword_n_in(req.lword_n),
        .vme_write_n_in(req.write_n), .vme_data_in(req.data),
        .vme_data_out(dout), .vme_data_oe_n_out(oe_n),
        .vme_dtack_n_out(dtack_n), .vme_berr_n_out(berr_n),
        .board_select_in(bsel), .frame_buffer_attached_n_in(fbn),
        .irq_event_in(irq_ev), .status_flags_in(flags), .irq_out(irq),
        .board_reset_out(brst), .fb_link_enable_out(fbl),
        .proc_run_out(run), .proc_start_out(start),
        .proc_from_zero_out(fz), .proc_bus_req_in(breq),
        .proc_bus_req_out(breq_out), .ustore_addr_out(uaddr),
        .ustore_col_out(ucol), .ustore_wr_out(uwr),
        .ustore_wdata_out(uwd), .ustore_rdata_in({ucol, uaddr[13:0]}));

    vme_host_model i_vme_host_model (.clk_in(clk_in), .dtack_n_in(dtack_n),
        .berr_n_in(berr_n), .rdata_in(dout), .req_out(req));

    function automatic logic [23:1] ra(input logic [1:0] s);
        return {bsel, 1'b0, 12'($urandom), s};
    endfunction : ra

    function automatic logic [23:1] ma(input logic [13:0] i);
        return {bsel, 1'b1, i};
    endfunction : ma

    function automatic logic ien_next(input logic en, input logic [1:0] c);
        return c == IEN_ON ? 1'b1 : c == IEN_OFF ? 1'b0 :
            c == IEN_TOG ? ~en : en;
    endfunction : ien_next

    task automatic chk(input string nm, input logic [63:0] seen,
        input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic acc(input logic [23:1] a, input logic wn,
        input logic [15:0] wd, input logic [1:0] ds);
        i_vme_host_model.host_cycle(a, $urandom % 2 ? AM_SUPER_DATA :
            AM_USER_DATA, ds, 1'b1, wn, wd, rd, rsp);
        chk("ack", rsp, 1);
        chk("drive", oe_last, !wn);
    endtask : acc

    task automatic refuse(input logic [23:1] a, input logic [5:0] am,
        input logic lw, input logic [1:0] exp);
        i_vme_host_model.host_cycle(a, am, 2'h0, lw, 1'b0, ~p, rd, rsp);
        chk("refused", rsp, exp);
    endtask : refuse

    task automatic conclude();
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    always @(posedge clk_in) begin
        breq <= 2'($urandom);
        if (!dtack_n) begin
            oe_last <= oe_n;
        end
        if (resetn) begin
            start_cnt <= start_cnt + int'(start[0]) + int'(start[1]);
        end
        if (uwr) begin
            wd_seen <= uwd;
            wa_seen <= {ucol, uaddr};
        end
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end

    // a request raised while a core starts must not pass
    always @(negedge clk_in) begin
        if (resetn && rq_ok) begin
            chk("bus_req", breq_out, rq_prev & ~st_prev);
        end
        rq_prev = breq;
        st_prev = start;
        rq_ok = resetn;
    end

    initial begin
        void'($urandom(32'h7419C5E4));
        bsel = 8'($urandom);
        repeat (4) @(posedge clk_in);
        chk("reset_out", {brst, run}, 3'h4);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_in);
        for (int j = 0; j < 2; j++) begin
            fbn <= j[0];
            repeat (4) @(posedge clk_in);
            acc(ra(SEL_IDENT), 1'b1, 16'h0000, 2'($urandom % 3));
            chk("ident", rd,
                {ID_HIGH_ONES, 7'h2A, j[0]});
            chk("link", fbl, !j[0]);
        end
        p = 16'($urandom);
        acc(ra(SEL_PTR), 1'b0, p, 2'($urandom % 3));
        refuse(ra(SEL_IDENT), AM_USER_DATA, 1'b1, 2'h2);
        refuse(ra(SEL_PTR), AM_SUPER_DATA, 1'b0, 2'h2);
        refuse(ma(14'h0000), AM_SUPER_DATA, 1'b0, 2'h2);
        refuse(ra(SEL_PTR), 6'h3E, 1'b1, 2'h0);
        refuse(ra(SEL_PTR) ^ {8'h01, 15'h0000}, AM_USER_DATA,
            1'b1, 2'h0);
        acc(ra(SEL_PTR), 1'b1, 16'h0000, 2'h0);
        chk("pointer", rd, p);
        acc(ra(SEL_CTRL), 1'b1, 16'h0000, 2'h1);
        chk("status", {rd[13:11], rd[7:0]}, {3'h1, flags});
        for (int k = 0; k < 4; k++) begin
            acc(ra(SEL_WIN), 1'b1, 16'h0000, 2'($urandom % 3));
            chk("window", rd, {k[1:0], p[13:0]});
        end
        acc(ra(SEL_PTR), 1'b1, 16'h0000, 2'h0);
        chk("advance", rd, 16'(p + 16'h0001));
        d = 16'($urandom);
        acc(ra(SEL_WIN), 1'b0, d, 2'h2);
        chk("win_write", {wa_seen, wd_seen},
            {2'h0, 15'(p + 16'h0001), d});
        acc(ra(SEL_CTRL), 1'b1, 16'h0000, 2'h0);
        chk("column", rd[13:12], 2'h1);
        acc(ra(SEL_PTR), 1'b0, p, 2'h0);
        acc(ra(SEL_CTRL), 1'b1, 16'h0000, 2'h0);
        chk("col_zero", rd[13:12], 2'h0);
        for (int i = 0; i < 8; i++) begin
            idx[i] = i == 7 ? 14'h3FFF : {11'($urandom), i[2:0]};
            mem[i] = 16'($urandom);
            d = 16'($urandom);
            acc(ma(idx[i]), 1'b0, mem[i], 2'h0);
            acc(ma(idx[i]), 1'b0, d, 2'h2);
            mem[i][7:0] = d[7:0];
        end
        for (int i = 0; i < 8; i++) begin
            acc(ma(idx[i]), 1'b1, 16'h0000, 2'($urandom % 3));
            chk("memory", rd, mem[i]);
        end
        acc(ra(SEL_PTR), 1'b1, 16'h0000, 2'h0);
        chk("no_alias", rd, p);
        e = 1'b0;
        for (int i = 0; i < 8; i++) begin
            flags <= 8'($urandom);
            acc(ra(SEL_CTRL), 1'b0, {6'h00, i[1:0], 8'h00}, 2'h0);
            e = ien_next(e, i[1:0]);
            acc(ra(SEL_CTRL), 1'b1, 16'h0000, 2'h0);
            chk("enable", {rd[14], rd[7:0]}, {e, flags});
        end
        for (int i = 0; i < 2; i++) begin
            irq_ev <= 1'b1;
            @(posedge clk_in);
            irq_ev <= 1'b0;
            repeat (3) @(posedge clk_in);
            chk("irq", irq, !i[0]);
            acc(ra(SEL_CTRL), 1'b0, i[0] ? 16'h0000 : 16'h8200,
                2'h0);
            chk("irq_clear", irq, 1'b0);
        end
        // first start from zero then halt primes the pipeline
        for (int i = 0; i < 10; i++) begin
            acc(ra(SEL_CTRL), 1'b0, run_tbl[i][15:0], 2'h0);
            chk("run", {run, fz},
                run_tbl[i][19:16]);
        end
        // one single-cycle pulse per start: three painting, one viewing
        chk("starts", start_cnt, 4);
        acc(ra(SEL_CTRL), 1'b0, 16'h0040, 2'h0);
        chk("halted", {brst, run}, 3'h4);
        acc(ra(SEL_CTRL), 1'b1, 16'h0000, 2'h0);
        chk("rst_status", rd[15:8], 8'h0C);
        acc(ra(SEL_CTRL), 1'b0, 16'h0000, 2'h0);
        chk("released", brst, 1'b0);
        conclude();
    end
endmodule : test_vme_slave_register_and_run_control

`default_nettype wire
